// file: logic/irq_sync_pkg.sv
// Constants for interrupt pin and frame sync association configuration
package irq_sync_pkg;
   // Register offsets on the microprocessor port
   localparam logic [7:0] ADDR_SYNC_CTRL = 8'h34;
   localparam logic [7:0] ADDR_SYNC_REF  = 8'h7a;
   localparam logic [7:0] ADDR_IRQ_CFG   = 8'h7d;

   // Field positions
   localparam int SYNC_EN_BIT      = 7;
   localparam int IRQ_POL_BIT      = 0;
   localparam int IRQ_TRI_BIT      = 1;
   localparam int IRQ_GENOUT_BIT   = 2;
   localparam int SYNC_REF_W       = 4;

   // Reset values
   localparam logic [7:0] IRQ_CFG_RESET    = 8'h02;
   localparam logic [3:0] SYNC_REF_RESET   = 4'h0;
   localparam logic       SYNC_EN_RESET    = 1'b0;

   // Highest legal reference code
   localparam logic [3:0] SYNC_REF_MAX     = 4'he;
endpackage

// file: logic/irq_pin_cfg_if.sv
// Carrier of pin configuration from the register bank to the pin driver
`timescale 1ns/1ps
interface irq_pin_cfg_if;
   logic irq_pin_general_out_sel;
   logic drive_when_active_only;
   logic polarity;
   logic irq_request;

   modport bank (output irq_pin_general_out_sel, output drive_when_active_only,
                 output polarity, output irq_request);
   modport drv  (input irq_pin_general_out_sel, input drive_when_active_only,
                 input polarity, input irq_request);
endinterface

// file: logic/irq_pin_drv.sv
// Interrupt pin driver: level and output enable from configuration
`timescale 1ns/1ps
module irq_pin_drv
   import irq_sync_pkg::*;
(
   // Clock and reset
   input  wire logic     core_clk,
   input  wire logic     rst,
   // Configuration
   irq_pin_cfg_if.drv    cfg,
   // Pin
   output logic          pin_out,
   output logic          pin_oe_n
);
   logic next_pin_out;
   logic next_pin_oe_n;
   logic active;

   // Level and enable; general output is always an active state
   always_comb begin
      active = cfg.irq_pin_general_out_sel | cfg.irq_request;
      if (cfg.irq_pin_general_out_sel) begin
         next_pin_out = cfg.polarity;
      end else begin
         next_pin_out = cfg.irq_request ? cfg.polarity : ~cfg.polarity;
      end
      // Released when idle lets several sources share one wire
      next_pin_oe_n = cfg.drive_when_active_only & ~active;
   end

   // Registered so the pin never glitches on config writes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pin_out  <= 1'b0;
         pin_oe_n <= 1'b1;
      end else begin
         pin_out  <= next_pin_out;
         pin_oe_n <= next_pin_oe_n;
      end
   end
endmodule // irq_pin_drv

// file: logic/irq_pin_and_sync_assoc_cfg.sv
// Register bank for interrupt pin mode and frame sync reference association
`timescale 1ns/1ps
module irq_pin_and_sync_assoc_cfg
   import irq_sync_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // Microprocessor register port
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Device status
   input  wire logic       irq_event,
   input  wire logic       locked,
   input  wire logic [3:0] locked_ref,
   // Frame sync
   input  wire logic       ext_sync_in,
   output logic            ext_sync_accept,
   // Interrupt pin
   output logic            irq_pin_out,
   output logic            irq_pin_oe_n
);
   // Configuration state
   logic       general_out_sel;
   logic       tri_en;
   logic       pol;
   logic       sync_en;
   logic [3:0] sync_ref;
   logic       next_general_out_sel;
   logic       next_tri_en;
   logic       next_pol;
   logic       next_sync_en;
   logic [3:0] next_sync_ref;
   logic [7:0] next_reg_rdata;
   logic       next_ext_sync_accept;
   logic       ref_match;

   irq_pin_cfg_if pin_cfg ();

   // Decode shared by write and read paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      return a == target;
   endfunction

   // Write path; reserved bits are dropped
   always_comb begin
      next_general_out_sel = general_out_sel;
      next_tri_en   = tri_en;
      next_pol      = pol;
      next_sync_en  = sync_en;
      next_sync_ref = sync_ref;
      if (reg_wr && hit(reg_addr, ADDR_IRQ_CFG)) begin
         next_general_out_sel = reg_wdata[IRQ_GENOUT_BIT];
         next_tri_en  = reg_wdata[IRQ_TRI_BIT];
         next_pol     = reg_wdata[IRQ_POL_BIT];
      end
      if (reg_wr && hit(reg_addr, ADDR_SYNC_CTRL)) begin
         next_sync_en = reg_wdata[SYNC_EN_BIT];
      end
      if (reg_wr && hit(reg_addr, ADDR_SYNC_REF)) begin
         next_sync_ref = reg_wdata[SYNC_REF_W-1:0];
      end
   end

   // Configuration registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         general_out_sel <= IRQ_CFG_RESET[IRQ_GENOUT_BIT];
         tri_en   <= IRQ_CFG_RESET[IRQ_TRI_BIT];
         pol      <= IRQ_CFG_RESET[IRQ_POL_BIT];
         sync_en  <= SYNC_EN_RESET;
         sync_ref <= SYNC_REF_RESET;
      end else begin
         general_out_sel <= next_general_out_sel;
         tri_en   <= next_tri_en;
         pol      <= next_pol;
         sync_en  <= next_sync_en;
         sync_ref <= next_sync_ref;
      end
   end

   // Read path; unmapped offsets and unused bits read zero
   always_comb begin
      next_reg_rdata = reg_rdata;
      if (reg_rd) begin
         next_reg_rdata = 8'h00;
         if (hit(reg_addr, ADDR_IRQ_CFG)) begin
            next_reg_rdata[IRQ_GENOUT_BIT] = general_out_sel;
            next_reg_rdata[IRQ_TRI_BIT] = tri_en;
            next_reg_rdata[IRQ_POL_BIT] = pol;
         end
         if (hit(reg_addr, ADDR_SYNC_CTRL)) begin
            next_reg_rdata[SYNC_EN_BIT] = sync_en;
         end
         if (hit(reg_addr, ADDR_SYNC_REF)) begin
            next_reg_rdata[SYNC_REF_W-1:0] = sync_ref;
         end
      end
   end

   // Sync gate: code 1111 names no input, so nothing ever passes
   always_comb begin
      ref_match = locked && (locked_ref == sync_ref) && (sync_ref <= SYNC_REF_MAX);
      next_ext_sync_accept = ext_sync_in & sync_en & ref_match;
   end

   // Read data and sync gate registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata       <= 8'h00;
         ext_sync_accept <= 1'b0;
      end else begin
         reg_rdata       <= next_reg_rdata;
         ext_sync_accept <= next_ext_sync_accept;
      end
   end

   // Hand configuration to the pin driver
   assign pin_cfg.irq_pin_general_out_sel = general_out_sel;
   assign pin_cfg.drive_when_active_only  = tri_en;
   assign pin_cfg.polarity                = pol;
   assign pin_cfg.irq_request             = irq_event;

   irq_pin_drv u_pin (
      .core_clk (core_clk),
      .rst      (rst),
      .cfg      (pin_cfg),
      .pin_out  (irq_pin_out),
      .pin_oe_n (irq_pin_oe_n)
   );

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // Readback right after a write must return the code just written
   property p_sync_ref_store;
      reg_wr && reg_addr == ADDR_SYNC_REF ##1 reg_rd && reg_addr == ADDR_SYNC_REF
         |=> reg_rdata[SYNC_REF_W-1:0] == $past(reg_wdata[SYNC_REF_W-1:0], 2);
   endproperty
   a_sync_ref_store: assert property (p_sync_ref_store)
      else $error("sync reference field not stored");

   property p_sync_gate;
      ext_sync_accept |-> $past(ext_sync_in) && $past(sync_en) && $past(locked)
         && $past(locked_ref) == $past(sync_ref);
   endproperty
   a_sync_gate: assert property (p_sync_gate)
      else $error("sync accepted while not locked to chosen reference");

   property p_sync_pass;
      ext_sync_in && sync_en && locked && locked_ref == sync_ref && sync_ref != 4'hf
         |=> ext_sync_accept;
   endproperty
   a_sync_pass: assert property (p_sync_pass)
      else $error("qualified sync was dropped");

   property p_general_out_level;
      general_out_sel |=> irq_pin_out == $past(pol) && !irq_pin_oe_n;
   endproperty
   a_general_out_level: assert property (p_general_out_level)
      else $error("general output level wrong");

   property p_cfg_store;
      reg_wr && reg_addr == ADDR_IRQ_CFG
         |=> general_out_sel == $past(reg_wdata[IRQ_GENOUT_BIT])
         && tri_en == $past(reg_wdata[IRQ_TRI_BIT]) && pol == $past(reg_wdata[IRQ_POL_BIT]);
   endproperty
   a_cfg_store: assert property (p_cfg_store)
      else $error("pin mode bits not stored");

   property p_tri_release;
      tri_en && !general_out_sel && !irq_event |=> irq_pin_oe_n;
   endproperty
   a_tri_release: assert property (p_tri_release)
      else $error("pin driven while inactive in shared mode");

   property p_always_drive;
      !tri_en |=> !irq_pin_oe_n;
   endproperty
   a_always_drive: assert property (p_always_drive)
      else $error("pin released in always-driven mode");

   property p_reserved_zero;
      reg_rd && reg_addr == ADDR_IRQ_CFG |=> reg_rdata[7:3] == 5'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("unused bits read nonzero");

   property p_irq_level;
      !general_out_sel && irq_event |=> irq_pin_out == $past(pol);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt active level wrong");

   // Idle level only shows when the pin is always driven
   property p_irq_idle_level;
      !general_out_sel && !irq_event && !tri_en |=> irq_pin_out == !$past(pol);
   endproperty
   a_irq_idle_level: assert property (p_irq_idle_level)
      else $error("interrupt idle level wrong");

   property p_code_f_refused;
      sync_ref == 4'hf |=> !ext_sync_accept;
   endproperty
   a_code_f_refused: assert property (p_code_f_refused)
      else $error("sync accepted for unassigned code");

   property p_reset_config;
      $past(rst) |-> general_out_sel == IRQ_CFG_RESET[IRQ_GENOUT_BIT]
         && tri_en == IRQ_CFG_RESET[IRQ_TRI_BIT] && pol == IRQ_CFG_RESET[IRQ_POL_BIT];
   endproperty
   a_reset_config: assert property (p_reset_config)
      else $error("pin mode bits wrong after reset");

   c_sync_pass: cover property (ext_sync_accept);
   c_general_out_mode: cover property (general_out_sel && !irq_pin_oe_n);
   c_shared_irq: cover property (tri_en && irq_event ##1 !irq_pin_oe_n);
   c_refused_sync: cover property (ext_sync_in && sync_en && !locked);
endmodule // irq_pin_and_sync_assoc_cfg

// file: sim/irq_host_model.sv
// Host processor model: biased interrupt line and active detection
`timescale 1ns/1ps
module irq_host_model (
   // Pin from device
   input  wire logic pin_out,
   input  wire logic pin_oe_n,
   input  wire logic pol,
   // Resolved line
   output logic      line,
   output logic      irq_seen
);
   // Bias resistor pulls a released line to the idle level
   assign line     = pin_oe_n ? ~pol : pin_out;
   // Host reads the line as active at the programmed level
   assign irq_seen = (line === pol);
endmodule // irq_host_model

// file: sim/testbench.sv
// Self-checking bench for the interrupt pin and sync association bank
`timescale 1ns/1ps
module testbench;
   import irq_sync_pkg::*;
   logic       core_clk, rst, reg_wr, reg_rd, irq_event, locked, ext_sync_in, pol;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [3:0] locked_ref;
   logic       ext_sync_accept, irq_pin_out, irq_pin_oe_n, line, irq_seen;
   int         err_total, samples_checked;

   irq_pin_and_sync_assoc_cfg dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq_event(irq_event), .locked(locked), .locked_ref(locked_ref),
      .ext_sync_in(ext_sync_in), .ext_sync_accept(ext_sync_accept),
      .irq_pin_out(irq_pin_out), .irq_pin_oe_n(irq_pin_oe_n));
   irq_host_model host_u (.pin_out(irq_pin_out), .pin_oe_n(irq_pin_oe_n), .pol(pol),
      .line(line), .irq_seen(irq_seen));

   // Free-running core clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic chk(string what, logic [7:0] exp, logic [7:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One-cycle strobes; an idle cycle after each keeps back-to-back calls apart
   task automatic wr(logic [7:0] a, logic [7:0] d);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge core_clk);
      reg_wr    = 1'b0;
      @(negedge core_clk);
   endtask

   task automatic rd(logic [7:0] a, logic [7:0] exp);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge core_clk);
      reg_rd   = 1'b0;
      chk("reg_rdata", exp, reg_rdata);
      @(negedge core_clk);
   endtask

   // Write then read the same offset on the very next cycle
   task automatic wr_rd(logic [7:0] a, logic [7:0] d, logic [7:0] exp);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge core_clk);
      reg_wr    = 1'b0;
      reg_rd    = 1'b1;
      @(negedge core_clk);
      reg_rd    = 1'b0;
      chk("reg_rdata", exp, reg_rdata);
      @(negedge core_clk);
   endtask

   task automatic close_out();
      $display("compares %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Defaults after reset, plus an unmapped offset
   task automatic t_reset();
      chk("oe_n after reset", 1'b1, irq_pin_oe_n);
      rd(ADDR_IRQ_CFG, IRQ_CFG_RESET);
      rd(8'h00, 8'h00);
      wr(8'h00, 8'hff);
      rd(ADDR_IRQ_CFG, IRQ_CFG_RESET);
   endtask

   // Every mode, drive and polarity with and without an event
   task automatic t_pin();
      logic [2:0] c;
      logic       act;
      for (int k = 0; k < 16; k++) begin
         c = k[2:0];
         wr(ADDR_IRQ_CFG, {5'h1f, c});
         irq_event = k[3];
         pol       = c[IRQ_POL_BIT];
         @(negedge core_clk);
         act = k[3] | c[IRQ_GENOUT_BIT];
         chk("irq_pin_oe_n", c[IRQ_TRI_BIT] & ~act, irq_pin_oe_n);
         chk("irq_seen", act, irq_seen);
         rd(ADDR_IRQ_CFG, {5'h00, c});
      end
      irq_event = 1'b0;
   endtask

   // Sync gated by enable, lock and matching reference code
   task automatic t_sync();
      wr(ADDR_SYNC_CTRL, 8'h80);
      rd(ADDR_SYNC_CTRL, 8'h80);
      locked      = 1'b1;
      ext_sync_in = 1'b1;
      for (int k = 0; k <= SYNC_REF_MAX; k++) begin
         wr_rd(ADDR_SYNC_REF, 8'(k), 8'(k));
         locked_ref = 4'(k);
         @(negedge core_clk);
         chk("accept match", 1'b1, ext_sync_accept);
         locked_ref = 4'(k + 1);
         @(negedge core_clk);
         chk("accept other ref", 1'b0, ext_sync_accept);
      end
      locked_ref = SYNC_REF_MAX;
      locked     = 1'b0;
      @(negedge core_clk);
      chk("accept unlocked", 1'b0, ext_sync_accept);
      locked      = 1'b1;
      ext_sync_in = 1'b0;
      @(negedge core_clk);
      chk("accept no sync", 1'b0, ext_sync_accept);
      ext_sync_in = 1'b1;
      wr(ADDR_SYNC_CTRL, 8'h00);
      @(negedge core_clk);
      chk("accept disabled", 1'b0, ext_sync_accept);
      // Code 1111 names no input even when the lock code agrees
      wr(ADDR_SYNC_CTRL, 8'h80);
      wr(ADDR_SYNC_REF, 8'h0f);
      locked_ref = 4'hf;
      @(negedge core_clk);
      chk("accept code f", 1'b0, ext_sync_accept);
      ext_sync_in = 1'b0;
   endtask

   // Cut a hang short
   initial begin
      #300000;
      err_total++;
      close_out();
   end

   initial begin
      rst = 1'b1;
      {reg_wr, reg_rd, irq_event, locked, ext_sync_in, pol} = 6'h00;
      reg_addr   = 8'h00;
      reg_wdata  = 8'h00;
      locked_ref = 4'h0;
      repeat (20) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      t_reset();
      t_pin();
      t_sync();
      close_out();
   end
endmodule // testbench
